// File: src/pmc_defines.svh
// Constants for the programmable macrocell: sizes, term slots, reset values.
// Assumes inclusion by bare name; definitions only.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ****************************************
// Sizes
// ****************************************
`define PMC_NTERMS     6
`define PMC_TERM_W     4
`define PMC_OE_TERMS   4
`define PMC_OE_SEL_W   2

// ****************************************
// Control term slots
// ****************************************
`define PMC_TERM_PRESET 0
`define PMC_TERM_RESET  1
`define PMC_OE_BASE     2

// ****************************************
// Reset values
// ****************************************
`define PMC_STATE_RST  1'b0
`define PMC_SYNC_RST   1'b0
`define PMC_FLOAT_RST  1'b0

`endif

// File: src/pmc_macrocell.sv
// One configurable output cell: flip-flop, clock choice, control terms,
// output buffer enable and two feedback returns.
// Assumes one clock mclk at 40 MHz; pins and pin clocks are asynchronous
// and are synchronised here; term and data inputs come from mclk logic.
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_macrocell (
  input  wire logic                      mclk,              // System clock, 40 MHz
  input  wire logic                      rst,               // Async reset, active high
  input  wire logic                      sync_clock_in,     // Synchronous clock pin
  input  wire logic                      alt_clock_in,      // Alternate clock pin
  input  wire logic                      alt_clock_logic,   // Alternate clock from logic
  input  wire logic                      global_float_n,    // Global float pin, low floats
  input  wire logic                      data_in,           // Flip-flop D or T input
  input  wire logic [`PMC_NTERMS*`PMC_TERM_W-1:0] term_inputs,  // Term inputs, 4 per term
  input  wire logic [`PMC_NTERMS*`PMC_TERM_W-1:0] term_use,     // Term input use mask
  input  wire logic [`PMC_NTERMS-1:0]    term_is_sum,       // 1 sum, 0 product per term
  input  wire pmc_pkg::pmc_ff_mode_type  cfg_ff_mode,       // Data or toggle
  input  wire logic                      cfg_falling_edge,  // 1 capture on falling edge
  input  wire pmc_pkg::pmc_clk_sel_type  cfg_clk_sel,       // Sync or alternate clock
  input  wire pmc_pkg::pmc_alt_src_type  cfg_alt_src,       // Alternate clock source
  input  wire logic                      cfg_setclr_enable, // Preset/reset enable
  input  wire pmc_pkg::pmc_oe_mode_type  cfg_oe_mode,       // Buffer enable mode
  input  wire logic [`PMC_OE_SEL_W-1:0]  cfg_oe_term_sel,   // Which enable term
  input  wire logic                      io_pin_in,         // Level seen on the pin
  output logic                           io_pin_out,        // Value driven to the pin
  output logic                           io_pin_oe,         // High while pin driven
  output logic                           macro_feedback,    // Pre-buffer return
  output logic                           pin_feedback,      // Post-buffer return
  output logic [`PMC_NTERMS-1:0]         control_terms      // Evaluated control terms
);
  import pmc_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic sclk_s1_q, sclk_s2_q, sclk_prev_q;
  logic aclk_s1_q, aclk_s2_q;
  logic alt_prev_q;
  logic float_s1_q, float_s2_q;
  logic pin_s1_q, pin_s2_q;

  // Two flip-flops on every pin before any logic looks at it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_s1_q  <= `PMC_SYNC_RST;
      sclk_s2_q  <= `PMC_SYNC_RST;
      aclk_s1_q  <= `PMC_SYNC_RST;
      aclk_s2_q  <= `PMC_SYNC_RST;
      float_s1_q <= `PMC_FLOAT_RST;
      float_s2_q <= `PMC_FLOAT_RST;
      pin_s1_q   <= `PMC_SYNC_RST;
      pin_s2_q   <= `PMC_SYNC_RST;
    end else begin
      sclk_s1_q  <= sync_clock_in;
      sclk_s2_q  <= sclk_s1_q;
      aclk_s1_q  <= alt_clock_in;
      aclk_s2_q  <= aclk_s1_q;
      float_s1_q <= global_float_n;
      float_s2_q <= float_s1_q;
      pin_s1_q   <= io_pin_in;
      pin_s2_q   <= pin_s1_q;
    end
  end

  // ****************************************
  // Control terms
  // ****************************************
  genvar t;
  generate
    for (t = 0; t < `PMC_NTERMS; t = t + 1) begin : g_term
      logic [`PMC_TERM_W-1:0] in_v;
      logic [`PMC_TERM_W-1:0] use_v;
      assign in_v  = term_inputs[t*`PMC_TERM_W +: `PMC_TERM_W];
      assign use_v = term_use[t*`PMC_TERM_W +: `PMC_TERM_W];
      // Sum of used inputs, or product with unused inputs as ones
      assign control_terms[t] = term_is_sum[t] ? |(in_v & use_v)
                                               : &(in_v | ~use_v);
    end
  endgenerate

  // ****************************************
  // Clock selection and edge detection
  // ****************************************
  logic alt_level;
  logic sel_level;
  logic sel_prev;
  logic clk_edge;

  // Alternate clock from pin or internal logic
  assign alt_level = (cfg_alt_src == PMC_ALT_PIN) ? aclk_s2_q : alt_clock_logic;

  // Synchronous clock always comes from the pin
  assign sel_level = (cfg_clk_sel == PMC_CLK_SYNC) ? sclk_s2_q : alt_level;
  assign sel_prev  = (cfg_clk_sel == PMC_CLK_SYNC) ? sclk_prev_q : alt_prev_q;

  // Active edge of the chosen clock, polarity set by configuration
  assign clk_edge = cfg_falling_edge ? (sel_prev & ~sel_level)
                                     : (~sel_prev & sel_level);

  // Previous levels for edge detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_prev_q <= `PMC_SYNC_RST;
      alt_prev_q  <= `PMC_SYNC_RST;
    end else begin
      sclk_prev_q <= sclk_s2_q;
      alt_prev_q  <= alt_level;
    end
  end

  // ****************************************
  // Storage element
  // ****************************************
  logic state_q;
  logic preset_act;
  logic reset_act;

  // Set/clear terms, gated by the per-cell enable
  assign preset_act = cfg_setclr_enable & control_terms[`PMC_TERM_PRESET];
  assign reset_act  = cfg_setclr_enable & control_terms[`PMC_TERM_RESET];

  // Flip-flop; preset/reset do not wait for a selected clock edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= `PMC_STATE_RST;
    end else if (reset_act) begin
      state_q <= 1'b0;
    end else if (preset_act) begin
      state_q <= 1'b1;
    end else if (clk_edge) begin
      if (cfg_ff_mode == PMC_FF_TOGGLE) begin
        state_q <= state_q ^ data_in;
      end else begin
        state_q <= data_in;
      end
    end
  end

  // ****************************************
  // Output buffer and feedback
  // ****************************************
  logic oe_sel;

  // Enable term chosen from the four enable terms
  assign oe_sel = control_terms[`PMC_OE_BASE + {1'b0, cfg_oe_term_sel}];

  // Buffer enable: mode, then global float overrides
  always_comb begin
    unique case (cfg_oe_mode)
      PMC_OE_OFF:  io_pin_oe = 1'b0;
      PMC_OE_ON:   io_pin_oe = 1'b1;
      PMC_OE_TERM: io_pin_oe = oe_sel;
      default:     io_pin_oe = 1'b0;
    endcase
    if (!float_s2_q) begin
      io_pin_oe = 1'b0;
    end
  end

  // Pin data straight from the flip-flop
  assign io_pin_out = state_q;

  // Pre-buffer return carries the cell result regardless of the buffer
  assign macro_feedback = state_q;

  // Post-buffer return carries the pin level
  assign pin_feedback = pin_s2_q;

endmodule

// File: src/pmc_pkg.sv
// Types shared by the programmable macrocell.
// Assumes pmc_defines.svh is on the include path.
package pmc_pkg;

  // Storage element behaviour
  typedef enum logic {PMC_FF_DATA, PMC_FF_TOGGLE} pmc_ff_mode_type;

  // Clock source for the storage element
  typedef enum logic {PMC_CLK_SYNC, PMC_CLK_ALT} pmc_clk_sel_type;

  // Source of the alternate clock
  typedef enum logic {PMC_ALT_PIN, PMC_ALT_LOGIC} pmc_alt_src_type;

  // Output buffer enable source
  typedef enum logic [1:0] {PMC_OE_OFF, PMC_OE_ON, PMC_OE_TERM} pmc_oe_mode_type;

endpackage

// File: verification/pmc_macrocell_chk.sv
// Concurrent checks on the macrocell ports.
// Assumes a bind into pmc_macrocell, one mclk domain.
`timescale 1ns/1ps
module pmc_macrocell_chk (
  input wire logic                     mclk,
  input wire logic                     rst,
  input wire logic                     global_float_n,
  input wire logic                     cfg_setclr_enable,
  input wire pmc_pkg::pmc_oe_mode_type cfg_oe_mode,
  input wire logic [1:0]               cfg_oe_term_sel,
  input wire logic                     io_pin_out,
  input wire logic                     io_pin_oe,
  input wire logic                     macro_feedback,
  input wire logic                     pin_feedback,
  input wire logic [5:0]               control_terms
);
  import pmc_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_clear_wins: assert property (
    cfg_setclr_enable && control_terms[1] |=> !macro_feedback) else $error("no clear");
  a_preset_sets: assert property (
    cfg_setclr_enable && control_terms[0] && !control_terms[1] |=> macro_feedback)
    else $error("no preset");
  a_float_off: assert property (!global_float_n [*3] |-> !io_pin_oe) else $error("float");
  a_oe_off: assert property (cfg_oe_mode == PMC_OE_OFF |-> !io_pin_oe) else $error("oe");
  a_oe_on: assert property (
    global_float_n [*3] ##0 cfg_oe_mode == PMC_OE_ON |-> io_pin_oe) else $error("oe on");
  a_oe_term: assert property (
    global_float_n [*3] ##0 cfg_oe_mode == PMC_OE_TERM
    |-> io_pin_oe == control_terms[cfg_oe_term_sel + 3'h2]) else $error("oe term");
  a_pin_drive: assert property (
    io_pin_oe |-> io_pin_out == macro_feedback) else $error("pin value");
  a_pin_return: assert property (
    io_pin_oe [*3] |-> pin_feedback == $past(io_pin_out, 2)) else $error("pin return");
endmodule

// File: verification/pmc_macrocell_tb_top.sv
// Self-checking bench for the macrocell, one task per scenario.
// Assumes design, package, pin model and checker compiled first.
`timescale 1ns/1ps
module pmc_macrocell_tb_top;
  import pmc_pkg::*;
  logic mclk = 1'h0, rst = 1'h1, sync_clock_in = 1'h0, alt_clock_in = 1'h0;
  logic alt_clock_logic = 1'h0, global_float_n = 1'h1, data_in = 1'h0;
  logic cfg_falling_edge = 1'h0, cfg_setclr_enable = 1'h0, ext_en = 1'h0, ext_val = 1'h0;
  logic [23:0] term_inputs = 24'h0, term_use = 24'h111111;
  logic [5:0] term_is_sum = 6'h3F, control_terms;
  logic [1:0] cfg_oe_term_sel = 2'h0;
  logic io_pin_in, io_pin_out, io_pin_oe, macro_feedback, pin_feedback;
  pmc_ff_mode_type cfg_ff_mode = PMC_FF_DATA;
  pmc_clk_sel_type cfg_clk_sel = PMC_CLK_SYNC;
  pmc_alt_src_type cfg_alt_src = PMC_ALT_PIN;
  pmc_oe_mode_type cfg_oe_mode = PMC_OE_OFF;
  int fail_count = 0, n_checks = 0;
  pmc_macrocell DUT (.*);
  pmc_pin_model u_pin (.*);
  initial forever #12.5 mclk = ~mclk;
  // Compares one settled value now
  task automatic chk_now(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s exp %b got %b", nm, e, g);
    end
  endtask
  // Waits n edges, compares the live signal once settled, then waits one edge
  task automatic chk(int n, string nm, logic e, ref logic g);
    repeat (n) @(posedge mclk);
    #1;
    chk_now(nm, e, g);
    @(posedge mclk);
  endtask
  task results;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_setclr;
    cfg_setclr_enable <= 1'h1;
    term_inputs <= 24'h1;
    chk(1, "preset", 1'h1, macro_feedback);
    cfg_setclr_enable <= 1'h0;
    term_inputs <= 24'h10;
    chk(2, "terms ignored", 1'h1, macro_feedback);
    cfg_setclr_enable <= 1'h1;
    term_inputs <= 24'h11;
    chk(1, "clear wins", 1'h0, macro_feedback);
    cfg_setclr_enable <= 1'h0;
  endtask
  // Step: clk_sel, alt_src, toggle, falling, data, source, state high, state low
  task t_clock;
    logic [8:0] st [9] = '{9'h013, 9'h022, 9'h053, 9'h050, 9'h040, 9'h110, 9'h117,
                           9'h187, 9'h188};
    for (int i = 0; i < 9; i++) begin
      cfg_clk_sel <= pmc_clk_sel_type'(st[i][8]);
      cfg_alt_src <= pmc_alt_src_type'(st[i][7]);
      cfg_ff_mode <= pmc_ff_mode_type'(st[i][6]);
      {cfg_falling_edge, data_in} <= st[i][5:4];
      {alt_clock_logic, alt_clock_in, sync_clock_in} <= 3'h1 << st[i][3:2];
      chk(5, "clock high", st[i][1], macro_feedback);
      {alt_clock_logic, alt_clock_in, sync_clock_in} <= 3'h0;
      chk(5, "clock low", st[i][0], macro_feedback);
    end
  endtask
  task t_oe;
    cfg_setclr_enable <= 1'h1;
    term_inputs <= 24'h1;
    cfg_oe_mode <= PMC_OE_ON;
    chk(3, "pin return", 1'h1, pin_feedback);
    cfg_setclr_enable <= 1'h0;
    cfg_oe_mode <= PMC_OE_TERM;
    for (int s = 0; s < 4; s++) begin
      cfg_oe_term_sel <= 2'(s);
      term_inputs <= 24'h100 << (4 * s);
      chk(1, "enable term", 1'h1, io_pin_oe);
      term_inputs <= 24'h111100 ^ (24'h100 << (4 * s));
      chk(1, "other terms", 1'h0, io_pin_oe);
    end
    cfg_oe_mode <= PMC_OE_ON;
    global_float_n <= 1'h0;
    chk(3, "float", 1'h0, io_pin_oe);
    global_float_n <= 1'h1;
    cfg_oe_mode <= PMC_OE_OFF;
    ext_en <= 1'h1;
    chk(3, "pin input", 1'h0, pin_feedback);
    chk(0, "buried result", 1'h1, macro_feedback);
  endtask
  task t_terms;
    logic [23:0] v, u;
    logic [5:0] sm;
    logic e;
    u = 24'hF3A50C;
    sm = 6'h2A;
    term_use <= u;
    term_is_sum <= sm;
    for (int i = 1; i < 5; i++) begin
      v = 24'(24'h5A3C96 * i);
      term_inputs <= v;
      #1;
      for (int t = 0; t < 6; t++) begin
        e = sm[t] ? |(v[4*t+:4] & u[4*t+:4]) : &(v[4*t+:4] | ~u[4*t+:4]);
        chk_now("control term", e, control_terms[t]);
      end
      @(posedge mclk);
    end
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    chk(1, "power-up state", 1'h0, macro_feedback);
    t_setclr;
    t_clock;
    t_oe;
    t_terms;
    results;
  end
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    results;
  end
endmodule
bind pmc_macrocell pmc_macrocell_chk u_chk (.*);

// File: verification/pmc_pin_model.sv
// Far side of one macrocell pin: outside driver and pin level.
// Assumes the pin is split into value, enable and level in.
`timescale 1ns/1ps
module pmc_pin_model (
  input  wire logic mclk,       // System clock
  input  wire logic io_pin_out, // Design drive value
  input  wire logic io_pin_oe,  // Design drive enable
  input  wire logic ext_en,     // Outside driver on
  input  wire logic ext_val,    // Outside driver value
  output logic      io_pin_in   // Resolved pin level
);
  logic flt_q = 1'h0;
  // Undriven pin changes every cycle
  always @(posedge mclk) flt_q <= ~flt_q;
  // Pin level from all drivers
  assign io_pin_in = io_pin_oe ? io_pin_out : (ext_en ? ext_val : flt_q);
endmodule
